// *** shared/ecm_pkg.sv ***
// Constants for the error counter mapping bank
package ecm_pkg;
  // ----------------------------------------
  // Indirect addresses
  // ----------------------------------------
  localparam logic [6:0] ADDR_FRAME_LOSS   = 7'h05;
  localparam logic [6:0] ADDR_PATTERN_LO   = 7'h06;
  localparam logic [6:0] ADDR_PATTERN_HI   = 7'h07;
  localparam logic [6:0] ADDR_LINE_LO      = 7'h08;
  localparam logic [6:0] ADDR_LINE_HI      = 7'h09;
  localparam logic [6:0] ADDR_NATCRC_LO    = 7'h0A;
  localparam logic [6:0] ADDR_NATCRC_HI    = 7'h0B;
  localparam logic [6:0] ADDR_FARBLK_LO    = 7'h0C;
  localparam logic [6:0] ADDR_FARBLK_HI    = 7'h0D;
  localparam logic [6:0] ADDR_NATFAR_LO    = 7'h0E;
  localparam logic [6:0] ADDR_NATFAR_HI    = 7'h0F;
  // ----------------------------------------
  // Counter layout
  // ----------------------------------------
  localparam int CNT_N      = 6;
  localparam int CNT_MAX_W  = 16;
  localparam int IDX_FRAME  = 0;
  localparam int IDX_PATT   = 1;
  localparam int IDX_LINE   = 2;
  localparam int IDX_NATCRC = 3;
  localparam int IDX_FARBLK = 4;
  localparam int IDX_NATFAR = 5;
  localparam int CNT_W [CNT_N] = '{5, 16, 16, 10, 10, 10};
  localparam int HI_SHIFT   = 4;
  localparam logic [15:0] CNT_RST = 16'h0000;
  localparam logic [7:0]  RD_ZERO = 8'h00;
  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam longint UPDATE_PERIOD_NS = 1000000000;
  localparam longint CLK_PERIOD_NS    = 4;
  localparam int     UPDATE_CYCLES    = int'(UPDATE_PERIOD_NS / CLK_PERIOD_NS);
endpackage

// *** design/ecm_counter_map.sv ***
// Error counter mapping bank with group snapshot and indirect read port
// Behaviour
// [RQ1] Five-bit read-only count of basic frame synchronization losses.
// [RQ2] Sixteen-bit pattern detector error count at 06H low, 07H high.
// [RQ3] Sixteen-bit line code violation count at 08H and 09H.
// [RQ4] Ten-bit national-bit CRC count; low at 0AH, top bits 5:4 of 0BH.
// [RQ5] Ten-bit far end block error count; low 0CH, top bits 5:4 of 0DH.
// [RQ6] Ten-bit national-bit far block count; low 0EH, top bits 5:4 0FH.
// [RQ7] Count LSB at bit 0 of lower address, MSB in higher register.
// [RQ8] All mapping fields read-only and zero after reset.
// [RQ9] Manual update bit rising edge refreshes whole group together.
// [RQ10] Auto update bit set refreshes whole group once every second.
// [RQ11] Each update copies accumulators and restarts them, losing no event.
`timescale 1ns/100ps
`default_nettype none
module ecm_counter_map #(
  parameter int UPDATE_CYCLES = ecm_pkg::UPDATE_CYCLES
) (
  input  wire logic       mclk,
  input  wire logic       sys_rst,
  input  wire logic       frame_loss_evt,
  input  wire logic       pattern_err_evt,
  input  wire logic       line_violation_evt,
  input  wire logic       natbit_crc_evt,
  input  wire logic       far_block_evt,
  input  wire logic       natbit_far_evt,
  input  wire logic       manual_update_bit,
  input  wire logic       auto_update_bit,
  input  wire logic       rd_en,
  input  wire logic [6:0] rd_addr,
  output logic      [7:0] rd_data,
  output logic            rd_valid,
  output logic            update_done
);

  // ----------------------------------------
  // Parameter check
  // ----------------------------------------
  if (UPDATE_CYCLES < 2)
  begin : g_bad_period
    $error("UPDATE_CYCLES must be at least 2");
  end

  localparam int TW = $clog2(UPDATE_CYCLES);
  localparam logic [TW-1:0] TICK_LAST = TW'(UPDATE_CYCLES - 1);
  localparam logic [TW-1:0] TICK_ZERO = '0;

  // ----------------------------------------
  // Field positions inside a mapping value
  // ----------------------------------------
  localparam int BYTE_W    = 8;
  localparam int LO_MSB    = 7;
  localparam int HI16_LSB  = 8;
  localparam int HI16_MSB  = 15;
  localparam int HI10_LSB  = 8;
  localparam int HI10_MSB  = 9;
  localparam int FRAME_MSB = 4;

  // ----------------------------------------
  // Package consistency checks
  // ----------------------------------------
  for (genvar k = 0; k < ecm_pkg::CNT_N; k++)
  begin : g_chk_width
    if (ecm_pkg::CNT_W[k] > ecm_pkg::CNT_MAX_W || ecm_pkg::CNT_W[k] < 1)
    begin : g_bad_width
      $error("Counter width out of range");
    end
  end

  if (ecm_pkg::HI_SHIFT + (HI10_MSB - HI10_LSB + 1) > BYTE_W)
  begin : g_bad_shift
    $error("High field does not fit a byte");
  end

  // ----------------------------------------
  // Byte views of a mapping value
  // ----------------------------------------
  function automatic logic [7:0] low_byte(input logic [15:0] v);
    low_byte = v[LO_MSB:0];
  endfunction

  function automatic logic [7:0] high16_byte(input logic [15:0] v);
    high16_byte = v[HI16_MSB:HI16_LSB];
  endfunction

  function automatic logic [7:0] high10_byte(input logic [15:0] v);
    logic [7:0] f;
    f = {6'h00, v[HI10_MSB:HI10_LSB]};
    high10_byte = 8'(f << ecm_pkg::HI_SHIFT);
  endfunction

  function automatic logic [7:0] frame_byte(input logic [15:0] v);
    frame_byte = {3'h0, v[FRAME_MSB:0]};
  endfunction

  // ----------------------------------------
  // Saturating increment within a width
  // ----------------------------------------
  function automatic logic [15:0] sat_inc(input logic [15:0] v, input int w);
    logic [15:0] lim;
    lim = 16'((32'h1 << w) - 1);
    if (v == lim)
    begin
      sat_inc = v;
    end
    else
    begin
      sat_inc = v + 16'h0001;
    end
  endfunction

  // ----------------------------------------
  // Update trigger
  // ----------------------------------------
  logic [TW-1:0] tick_r;
  logic [TW-1:0] tick_nxt;
  logic          man_prev_r;
  logic          man_prev_nxt;
  logic          upd;

  always_comb
  begin
    man_prev_nxt = manual_update_bit;
    tick_nxt     = tick_r;
    upd          = 1'b0;
    // [RQ9] Rising edge trigger
    if (manual_update_bit && !man_prev_r)
    begin
      upd = 1'b1;
    end
    // [RQ10] One second tick
    if (auto_update_bit)
    begin
      if (tick_r == TICK_LAST)
      begin
        tick_nxt = TICK_ZERO;
        upd      = 1'b1;
      end
      else
      begin
        tick_nxt = tick_r + 1'b1;
      end
    end
    else
    begin
      tick_nxt = TICK_ZERO;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      tick_r     <= TICK_ZERO;
      man_prev_r <= 1'b0;
    end
    else
    begin
      tick_r     <= tick_nxt;
      man_prev_r <= man_prev_nxt;
    end
  end

  // ----------------------------------------
  // Accumulators and mapping snapshot
  // ----------------------------------------
  logic [ecm_pkg::CNT_N-1:0] evt;
  logic [15:0]               acc_r   [ecm_pkg::CNT_N];
  logic [15:0]               acc_nxt [ecm_pkg::CNT_N];
  logic [15:0]               map_r   [ecm_pkg::CNT_N];
  logic [15:0]               map_nxt [ecm_pkg::CNT_N];

  assign evt[ecm_pkg::IDX_FRAME]  = frame_loss_evt;
  assign evt[ecm_pkg::IDX_PATT]   = pattern_err_evt;
  assign evt[ecm_pkg::IDX_LINE]   = line_violation_evt;
  assign evt[ecm_pkg::IDX_NATCRC] = natbit_crc_evt;
  assign evt[ecm_pkg::IDX_FARBLK] = far_block_evt;
  assign evt[ecm_pkg::IDX_NATFAR] = natbit_far_evt;

  for (genvar i = 0; i < ecm_pkg::CNT_N; i++)
  begin : g_cnt
    always_comb
    begin
      map_nxt[i] = map_r[i];
      acc_nxt[i] = evt[i] ? sat_inc(acc_r[i], ecm_pkg::CNT_W[i]) : acc_r[i];
      // [RQ11] Snapshot and restart
      if (upd)
      begin
        map_nxt[i] = acc_r[i];
        acc_nxt[i] = evt[i] ? 16'h0001 : ecm_pkg::CNT_RST;
      end
    end

    always_ff @(posedge mclk)
    begin
      // [RQ8] Zero after reset
      if (sys_rst)
      begin
        acc_r[i] <= ecm_pkg::CNT_RST;
        map_r[i] <= ecm_pkg::CNT_RST;
      end
      else
      begin
        acc_r[i] <= acc_nxt[i];
        map_r[i] <= map_nxt[i];
      end
    end
  end

  // ----------------------------------------
  // Indirect read port
  // ----------------------------------------
  logic [7:0] rd_data_nxt;
  logic [7:0] rd_data_r;
  logic       rd_valid_nxt;
  logic       rd_valid_r;

  always_comb
  begin
    rd_data_nxt  = rd_data_r;
    rd_valid_nxt = rd_en;
    if (rd_en)
    begin
      unique case (rd_addr)
        // [RQ1] Frame loss count
        ecm_pkg::ADDR_FRAME_LOSS:
        begin
          rd_data_nxt = frame_byte(map_r[ecm_pkg::IDX_FRAME]);
        end
        // [RQ2] Pattern errors split
        ecm_pkg::ADDR_PATTERN_LO:
        begin
          rd_data_nxt = low_byte(map_r[ecm_pkg::IDX_PATT]);
        end
        ecm_pkg::ADDR_PATTERN_HI:
        begin
          rd_data_nxt = high16_byte(map_r[ecm_pkg::IDX_PATT]);
        end
        // [RQ3] Line violations split
        ecm_pkg::ADDR_LINE_LO:
        begin
          rd_data_nxt = low_byte(map_r[ecm_pkg::IDX_LINE]);
        end
        ecm_pkg::ADDR_LINE_HI:
        begin
          rd_data_nxt = high16_byte(map_r[ecm_pkg::IDX_LINE]);
        end
        // [RQ4] National CRC split
        ecm_pkg::ADDR_NATCRC_LO:
        begin
          rd_data_nxt = low_byte(map_r[ecm_pkg::IDX_NATCRC]);
        end
        ecm_pkg::ADDR_NATCRC_HI:
        begin
          rd_data_nxt = high10_byte(map_r[ecm_pkg::IDX_NATCRC]);
        end
        // [RQ5] Far block split
        ecm_pkg::ADDR_FARBLK_LO:
        begin
          rd_data_nxt = low_byte(map_r[ecm_pkg::IDX_FARBLK]);
        end
        ecm_pkg::ADDR_FARBLK_HI:
        begin
          rd_data_nxt = high10_byte(map_r[ecm_pkg::IDX_FARBLK]);
        end
        // [RQ6] National far block split
        ecm_pkg::ADDR_NATFAR_LO:
        begin
          rd_data_nxt = low_byte(map_r[ecm_pkg::IDX_NATFAR]);
        end
        // [RQ7] MSB in higher address
        ecm_pkg::ADDR_NATFAR_HI:
        begin
          rd_data_nxt = high10_byte(map_r[ecm_pkg::IDX_NATFAR]);
        end
        default:
        begin
          rd_data_nxt = ecm_pkg::RD_ZERO;
        end
      endcase
    end
  end

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      rd_data_r  <= ecm_pkg::RD_ZERO;
      rd_valid_r <= 1'b0;
    end
    else
    begin
      rd_data_r  <= rd_data_nxt;
      rd_valid_r <= rd_valid_nxt;
    end
  end

  // ----------------------------------------
  // Update done pulse
  // ----------------------------------------
  logic done_nxt;
  logic done_r;

  always_comb
  begin
    done_nxt = upd;
  end

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      done_r <= 1'b0;
    end
    else
    begin
      done_r <= done_nxt;
    end
  end

  assign rd_data     = rd_data_r;
  assign rd_valid    = rd_valid_r;
  assign update_done = done_r;

endmodule
`default_nettype wire

// *** verif/ecm_counter_map_monitor.sv ***
// Checker for the counter mapping bank ports
`timescale 1ns/100ps
`default_nettype none
module ecm_mon (
  input wire logic       mclk,
  input wire logic       sys_rst,
  input wire logic       frame_loss_evt,
  input wire logic       pattern_err_evt,
  input wire logic       line_violation_evt,
  input wire logic       natbit_crc_evt,
  input wire logic       far_block_evt,
  input wire logic       natbit_far_evt,
  input wire logic       manual_update_bit,
  input wire logic       auto_update_bit,
  input wire logic       rd_en,
  input wire logic [6:0] rd_addr,
  input wire logic [7:0] rd_data,
  input wire logic       rd_valid,
  input wire logic       update_done
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (sys_rst);
  AST_RD_ACK: assert property (rd_en |=> rd_valid)
    else $error("read not answered");
  AST_RD_ONE: assert property (!rd_en |=> !rd_valid)
    else $error("read answer without request");
  AST_UNMAPPED: assert property ((rd_en && (rd_addr < 7'h05 || rd_addr > 7'h0F))
    |=> rd_data == 8'h00) else $error("unmapped address not zero");
  AST_HI10: assert property ((rd_en && rd_addr inside {7'h0B, 7'h0D, 7'h0F})
    |=> rd_data[7:6] == 2'h0 && rd_data[3:0] == 4'h0) else $error("high byte stray bits");
  AST_FRAME5: assert property ((rd_en && rd_addr == 7'h05)
    |=> rd_data[7:5] == 3'h0) else $error("frame loss field too wide");
  AST_MAN_UPD: assert property ($rose(manual_update_bit) |=> update_done)
    else $error("manual update missed");
  AST_UPD_CAUSE: assert property (update_done
    |-> $past(manual_update_bit) || $past(auto_update_bit)) else $error("update without cause");
  AST_HOLD: assert property (!rd_en |=> $stable(rd_data))
    else $error("read data moved without read");
  AST_RST: assert property (disable iff (1'h0) sys_rst
    |=> rd_data == 8'h00 && !rd_valid && !update_done) else $error("reset values wrong");
endmodule
bind ecm_counter_map ecm_mon mon_u (.mclk, .sys_rst, .frame_loss_evt, .pattern_err_evt,
  .line_violation_evt, .natbit_crc_evt, .far_block_evt, .natbit_far_evt, .manual_update_bit,
  .auto_update_bit, .rd_en, .rd_addr, .rd_data, .rd_valid, .update_done);
`default_nettype wire

// *** verif/ecm_counter_map_tb.sv ***
// Self-checking bench for the counter mapping bank
`timescale 1ns/100ps
`default_nettype none
module ecm_counter_map_tb;
  localparam int UC = 20;
  logic       mclk, sys_rst, man, aut, rd_en, rd_valid, update_done;
  logic [5:0] ev;
  logic [6:0] rd_addr;
  logic [7:0] rd_data;
  int         n_mismatch, comparisons, t, acc[6], snap[6];
  ecm_counter_map #(.UPDATE_CYCLES(UC)) dut_u (.mclk(mclk), .sys_rst(sys_rst),
    .frame_loss_evt(ev[0]), .pattern_err_evt(ev[1]), .line_violation_evt(ev[2]),
    .natbit_crc_evt(ev[3]), .far_block_evt(ev[4]), .natbit_far_evt(ev[5]),
    .manual_update_bit(man), .auto_update_bit(aut), .rd_en(rd_en), .rd_addr(rd_addr),
    .rd_data(rd_data), .rd_valid(rd_valid), .update_done(update_done));
  task automatic chk(logic [7:0] seen, logic [7:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  function automatic logic [7:0] ex(int a);
    int v;
    v = (a > 5 && a < 16) ? snap[a / 2 - 2] : 0;
    if (a == 5)
      return 8'(snap[0]);
    if (a % 2 == 0)
      return v[7:0];
    if (a < 10)
      return v[15:8];
    return {2'h0, v[9:8], 4'h0};
  endfunction
  task automatic rd_all();
    for (int a = 0; a < 18; a++)
    begin
      rd_en = 1'h1;
      rd_addr = 7'(a);
      @(negedge mclk);
      chk(8'(rd_valid), 8'h01);
      chk(rd_data, ex(a));
    end
    rd_en = 1'h0;
  endtask
  task automatic burst(int n);
    repeat (n)
    begin
      ev = 6'($urandom);
      for (int i = 0; i < 6; i++)
        if (acc[i] < (1 << ecm_pkg::CNT_W[i]) - 1)
          acc[i] += ev[i];
      @(negedge mclk);
    end
    ev = 6'h00;
  endtask
  task automatic take();
    for (int i = 0; i < 6; i++)
    begin
      snap[i] = acc[i];
      acc[i] = 0;
    end
  endtask
  task automatic wait_done(int s);
    t = s;
    while (update_done !== 1'h1 && t < 200)
    begin
      @(negedge mclk);
      t++;
    end
  endtask
  task automatic end_of_test();
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial
  begin
    mclk = 1'h0;
    forever #2 mclk = ~mclk;
  end
  initial
  begin
    #20000;
    n_mismatch++;
    end_of_test();
  end
  initial
  begin
    sys_rst = 1'h1;
    {man, aut, rd_en, ev, rd_addr} = '0;
    void'($urandom(39416));
    repeat (6) @(negedge mclk);
    sys_rst = 1'h0;
    rd_all();
    burst(1100);
    man = 1'h1;
    @(negedge mclk);
    chk(8'(update_done), 8'h01);
    man = 1'h0;
    take();
    rd_all();
    aut = 1'h1;
    wait_done(0);
    burst(10);
    wait_done(10);
    chk(8'(t), 8'(UC));
    aut = 1'h0;
    take();
    rd_all();
    end_of_test();
  end
endmodule
`default_nettype wire
